/* hdl/adc_serial_defs.vh */
// Purpose: Shared constants for the converter serial and mode control.
// Assumes: 40 MHz core clock; byte addresses are 6-bit register codes.
// Notes:   Include once; definitions only.
`ifndef ADC_SERIAL_DEFS_VH
`define ADC_SERIAL_DEFS_VH

// Communications byte layout
`define COMM_READ_BIT    6
// Register codes (bit 0 selects the channel where paired)
`define ADDR_STATUS      6'h04
`define ADDR_DATA0       6'h08
`define ADDR_CHSTAT0     6'h20
`define ADDR_ZS_ADC      6'h28
`define ADDR_ZS_CH0      6'h30
`define ADDR_FS_CH0      6'h32
`define ADDR_MODE0       6'h38
// Mode byte fields
`define MODE_FIELD_MSB   7
`define MODE_FIELD_LSB   5
`define MODE_DUMP_BIT    3
`define MODE_WIDE_BIT    1
// Operating mode codes
`define OPM_IDLE         3'h0
`define OPM_CONT         3'h1
`define OPM_SINGLE       3'h2
`define OPM_STANDBY      3'h3
`define OPM_ZS_SELF      3'h4
`define OPM_RESERVED     3'h5
`define OPM_CH_ZS        3'h6
`define OPM_CH_FS        3'h7
// Transfer lengths in bits
`define LEN_BYTE         6'h08
`define LEN_HALF         6'h10
`define LEN_WORD24       6'h18
`define LEN_DUMP         6'h08
// Serial reset: run of ones that resets the device
`define RESET_ONES       6'h20
// Timing
`define CLK_PERIOD_NS    25
`define CONV_TIME_NS     100000
`define CAL_TIME_NS      100000
`define CONV_CYCLES      (`CONV_TIME_NS / `CLK_PERIOD_NS)
`define CAL_CYCLES       (`CAL_TIME_NS / `CLK_PERIOD_NS)
`define TIMER_W          12

`endif

/* hdl/adc_serial_mode_control.v */
// Purpose: Serial access, mode control and ready signalling of a
//          two-channel converter.
// Assumes: Host link sampled by clk; conv_result comes from the
//          decimation filter on clk.
// Notes:   SPI mode 3: input taken on SCLK rise, output moved on fall.
//
// How it works
// - Self zero-scale cal end: update, all ready, idle
// - Channel zero-scale cal end: update, all ready
// - Channel full-scale cal end: update, all ready
// - Chip select high: ignore link, release output
// - Ready pin falls on completion or data
// - Ready pin always driven, never released
// - Two-wire: host turns line; no continuous read
// - Thirty-two ones on data input reset device
// - Hardware reset pin resets to default state
// - Comms byte first, then one register access
// - Mode write clears status, raises ready pin
// - Single conversion: update data, idle, ready
// - Data read clears its channel's ready bit; pin rises if no bit is left set
// - Dump bit prefixes channel status to data
// - Three-bit mode field, idle by default
// - Single conversion ignores channel enable bits
`timescale 1ns/1ps
`include "adc_serial_defs.vh"

module adc_serial_mode_control (
    // Clock and hardware reset pin
    input  wire        clk,
    input  wire        arst_n,
    // Host serial link
    input  wire        sclk,
    input  wire        cs_n,
    input  wire        din,
    output reg         dout,
    output reg         dout_oe,
    // Ready pin
    output reg         rdy_n,
    // Filter result
    input  wire [23:0] conv_result,
    // Converter state
    output reg  [2:0]  operating_mode_field,
    output wire        conv_busy
);

    // Serial states
    localparam [1:0] ST_COMM = 2'h0;
    localparam [1:0] ST_WR   = 2'h1;
    localparam [1:0] ST_RD   = 2'h2;

    // Synchronisers
    reg        sclk_s1;           // First stage
    reg        sclk_s2;           // Second stage
    reg        sclk_d;            // Delayed for edges
    reg        cs_n_s1;           // First stage
    reg        cs_n_s2;           // Second stage
    reg        din_s1;            // First stage
    reg        din_s2;            // Second stage
    wire       sclk_rise;         // Input sample point
    wire       sclk_fall;         // Output update point
    wire       selected;          // Chip select low

    // Serial engine
    reg [1:0]  st;                // Transaction phase
    reg [5:0]  bit_cnt;           // Bits in this phase
    reg [5:0]  xfer_len;          // Bits of the data phase
    reg [5:0]  addr;              // Addressed register
    reg [31:0] shreg;             // Shift register
    reg        rd_pending;        // Load on next fall
    reg [5:0]  ones_cnt;          // Run of ones seen
    reg        soft_rst;          // Serial reset pulse
    wire [7:0] in_byte;           // Byte with current bit

    // Mode register and ready state
    reg        dump;              // Status prefix enable
    reg        wide;              // 24-bit data reads
    reg        mode_ch;           // Channel of last mode write
    reg [1:0]  rdy_bits;          // Per-channel ready
    reg [1:0]  next_rdy;          // Ready after this cycle
    reg        mode_wr;           // Mode write commit
    reg        data_rd;           // Data register read
    reg [7:0]  mode_byte;         // Written mode value

    // Per-channel results and calibration
    reg [47:0] data_all;          // Data, 24 bits per channel
    reg [47:0] zs_all;            // Channel zero-scale cal
    reg [47:0] fs_all;            // Channel full-scale cal
    reg [23:0] zs_adc;            // Converter zero-scale cal

    // Read mux
    reg [31:0] rd_val;            // MSB-aligned read value
    reg [5:0]  rd_len;            // Read length in bits
    reg [23:0] sel_data;          // Addressed channel data
    reg [7:0]  sel_stat;          // Addressed channel status

    // Sequencer
    wire       seq_done;          // Operation finished
    wire [2:0] seq_mode;          // Which operation

    // Two flip-flops on every link pin before use
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_s1 <= 1'b1;
            sclk_s2 <= 1'b1;
            sclk_d  <= 1'b1;
            cs_n_s1 <= 1'b1;
            cs_n_s2 <= 1'b1;
            din_s1  <= 1'b0;
            din_s2  <= 1'b0;
        end else begin
            sclk_s1 <= sclk;
            sclk_s2 <= sclk_s1;
            sclk_d  <= sclk_s2;
            cs_n_s1 <= cs_n;
            cs_n_s2 <= cs_n_s1;
            din_s1  <= din;
            din_s2  <= din_s1;
        end
    end

    // Edges only count while selected
    assign selected  = ~cs_n_s2;
    assign sclk_rise = selected & sclk_s2 & ~sclk_d;
    assign sclk_fall = selected & ~sclk_s2 & sclk_d;
    assign in_byte   = {shreg[6:0], din_s2};

    // Addressed channel views
    always @* begin
        sel_data = addr[0] ? data_all[47:24] : data_all[23:0];
        sel_stat = {5'h00, sel_data[23], 1'b0, addr[0]};
    end

    // Read value and length by address
    always @* begin
        rd_val = 32'h00000000;
        rd_len = `LEN_BYTE;
        case (addr[5:1])
            `ADDR_STATUS >> 1: begin
                rd_val = {6'h00, rdy_bits, 24'h000000};
            end
            `ADDR_DATA0 >> 1, `ADDR_CHSTAT0 >> 1: begin
                if (dump) begin
                    // Status first, then data, whichever was addressed
                    rd_val = {sel_stat, sel_data};
                    rd_len = (wide ? `LEN_WORD24 : `LEN_HALF)
                             + `LEN_DUMP;
                end else if (addr[5:1] == (`ADDR_DATA0 >> 1)) begin
                    rd_val = {sel_data, 8'h00};
                    rd_len = wide ? `LEN_WORD24 : `LEN_HALF;
                end else begin
                    rd_val = {sel_stat, 24'h000000};
                end
            end
            `ADDR_ZS_ADC >> 1: begin
                rd_val = {zs_adc, 8'h00};
                rd_len = `LEN_WORD24;
            end
            `ADDR_ZS_CH0 >> 1: begin
                rd_val = {addr[0] ? zs_all[47:24] : zs_all[23:0], 8'h00};
                rd_len = `LEN_WORD24;
            end
            `ADDR_FS_CH0 >> 1: begin
                rd_val = {addr[0] ? fs_all[47:24] : fs_all[23:0], 8'h00};
                rd_len = `LEN_WORD24;
            end
            `ADDR_MODE0 >> 1: begin
                rd_val = {operating_mode_field, 1'b0, dump, 1'b0,
                          wide, 1'b0, 24'h000000};
            end
            default: begin
                rd_val = 32'h00000000;
            end
        endcase
        // A 16-bit dump read carries status, then data high bytes
        if (dump && !wide && (addr[5:1] == (`ADDR_DATA0 >> 1) ||
                addr[5:1] == (`ADDR_CHSTAT0 >> 1)))
            rd_val = {sel_stat, sel_data[23:8], 8'h00};
    end

    // Serial reset: a run of ones at any point while selected resets the device
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ones_cnt <= 6'h00;
            soft_rst <= 1'b0;
        end else begin
            soft_rst <= 1'b0;
            if (soft_rst) begin
                ones_cnt <= 6'h00;
            end else if (sclk_rise) begin
                if (!din_s2) begin
                    ones_cnt <= 6'h00;
                end else if (ones_cnt == `RESET_ONES - 6'h01) begin
                    ones_cnt <= 6'h00;
                    soft_rst <= 1'b1;
                end else begin
                    ones_cnt <= ones_cnt + 6'h01;
                end
            end
        end
    end

    // Transaction engine: comms byte, then one register access
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            st         <= ST_COMM;
            bit_cnt    <= 6'h00;
            xfer_len   <= `LEN_BYTE;
            addr       <= 6'h00;
            shreg      <= 32'h00000000;
            rd_pending <= 1'b0;
            dout       <= 1'b0;
            dout_oe    <= 1'b0;
        end else if (soft_rst || !selected) begin
            // Deselect abandons any partial access
            st         <= ST_COMM;
            bit_cnt    <= 6'h00;
            rd_pending <= 1'b0;
            dout_oe    <= selected;
        end else begin
            dout_oe <= 1'b1;
            if (sclk_rise) begin
                case (st)
                    ST_COMM: begin
                        shreg[7:0] <= in_byte;
                        bit_cnt    <= bit_cnt + 6'h01;
                        if (bit_cnt == 6'h07) begin
                            // Comms byte picks the one next access
                            addr    <= in_byte[5:0];
                            bit_cnt <= 6'h00;
                            if (in_byte[`COMM_READ_BIT]) begin
                                st         <= ST_RD;
                                rd_pending <= 1'b1;
                            end else begin
                                st       <= ST_WR;
                                xfer_len <= `LEN_BYTE;
                            end
                        end
                    end
                    ST_WR: begin
                        shreg[7:0] <= in_byte;
                        bit_cnt    <= bit_cnt + 6'h01;
                        if (bit_cnt == xfer_len - 6'h01) begin
                            st      <= ST_COMM;
                            bit_cnt <= 6'h00;
                        end
                    end
                    ST_RD: begin
                        bit_cnt <= bit_cnt + 6'h01;
                        if (bit_cnt == xfer_len - 6'h01) begin
                            st      <= ST_COMM;
                            bit_cnt <= 6'h00;
                        end
                    end
                    default: begin
                        st <= ST_COMM;
                    end
                endcase
            end else if (sclk_fall && st == ST_RD) begin
                if (rd_pending) begin
                    // First fall after comms byte presents the MSB
                    shreg      <= rd_val;
                    dout       <= rd_val[31];
                    xfer_len   <= rd_len;
                    rd_pending <= 1'b0;
                end else begin
                    shreg <= {shreg[30:0], 1'b0};
                    dout  <= shreg[30];
                end
            end
        end
    end

    // Commit and read side effects
    always @* begin
        mode_wr   = sclk_rise && selected && !soft_rst && st == ST_WR &&
                    bit_cnt == xfer_len - 6'h01 &&
                    addr[5:1] == (`ADDR_MODE0 >> 1);
        mode_byte = in_byte;
        data_rd   = sclk_fall && st == ST_RD && rd_pending &&
                    !soft_rst && addr[5:1] == (`ADDR_DATA0 >> 1);
    end

    // Ready bits: events set, mode write and data read clear
    always @* begin
        next_rdy = rdy_bits;
        if (mode_wr)
            next_rdy = 2'b00;
        if (data_rd)
            next_rdy[addr[0]] = 1'b0;
        if (seq_done) begin
            case (seq_mode)
                `OPM_SINGLE: next_rdy[mode_ch] = 1'b1;
                `OPM_ZS_SELF: next_rdy = 2'b11;
                `OPM_CH_ZS: next_rdy = 2'b11;
                `OPM_CH_FS: next_rdy = 2'b11;
                default: next_rdy = next_rdy;
            endcase
        end
    end

    // Mode register, ready state and ready pin
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            operating_mode_field <= `OPM_IDLE;
            dump     <= 1'b0;
            wide     <= 1'b0;
            mode_ch  <= 1'b0;
            rdy_bits <= 2'b00;
            rdy_n    <= 1'b1;
        end else if (soft_rst) begin
            operating_mode_field <= `OPM_IDLE;
            dump     <= 1'b0;
            wide     <= 1'b0;
            mode_ch  <= 1'b0;
            rdy_bits <= 2'b00;
            rdy_n    <= 1'b1;
        end else begin
            rdy_bits <= next_rdy;
            // Pin low while any channel has news; always driven
            rdy_n    <= ~|next_rdy;
            if (mode_wr) begin
                operating_mode_field <=
                    mode_byte[`MODE_FIELD_MSB:`MODE_FIELD_LSB];
                dump    <= mode_byte[`MODE_DUMP_BIT];
                wide    <= mode_byte[`MODE_WIDE_BIT];
                mode_ch <= addr[0];
            end else if (seq_done) begin
                // Timed operations fall back to idle
                operating_mode_field <= `OPM_IDLE;
            end
        end
    end

    // Per-channel result and calibration registers
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            always @(posedge clk or negedge arst_n) begin
                if (!arst_n) begin
                    data_all[ch*24 +: 24] <= 24'h000000;
                    zs_all[ch*24 +: 24]   <= 24'h000000;
                    fs_all[ch*24 +: 24]   <= 24'h000000;
                end else if (seq_done && mode_ch == ch) begin
                    // Enable bits are not consulted here
                    if (seq_mode == `OPM_SINGLE)
                        data_all[ch*24 +: 24] <= conv_result;
                    if (seq_mode == `OPM_CH_ZS)
                        zs_all[ch*24 +: 24] <= conv_result;
                    if (seq_mode == `OPM_CH_FS)
                        fs_all[ch*24 +: 24] <= conv_result;
                end
            end
        end
    endgenerate

    // Converter zero-scale calibration register
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            zs_adc <= 24'h000000;
        else if (seq_done && seq_mode == `OPM_ZS_SELF)
            zs_adc <= conv_result;
    end

    // Conversion and calibration timing
    conv_sequencer u_seq (
        .clk        (clk),
        .arst_n     (arst_n),
        .soft_rst   (soft_rst),
        .start      (mode_wr),
        .start_mode (mode_byte[`MODE_FIELD_MSB:`MODE_FIELD_LSB]),
        .busy       (conv_busy),
        .done       (seq_done),
        .done_mode  (seq_mode)
    );

endmodule

/* hdl/conv_sequencer.v */
// Purpose: Times one conversion or calibration and reports its end.
// Assumes: start is a one-cycle pulse from the serial control logic.
// Notes:   A new start while busy restarts the timer with the new mode, or stops it if that mode is untimed.
`timescale 1ns/1ps
`include "adc_serial_defs.vh"

module conv_sequencer (
    // Clock and reset
    input  wire                clk,
    input  wire                arst_n,
    input  wire                soft_rst,
    // Request
    input  wire                start,
    input  wire [2:0]          start_mode,
    // Progress
    output reg                 busy,
    output reg                 done,
    output reg  [2:0]          done_mode
);

    // Last cycle index of each timed operation
    localparam integer        CONV_LAST_I = `CONV_CYCLES - 1;
    localparam integer        CAL_LAST_I  = `CAL_CYCLES - 1;
    localparam [`TIMER_W-1:0] CONV_LAST   = CONV_LAST_I[`TIMER_W-1:0];
    localparam [`TIMER_W-1:0] CAL_LAST    = CAL_LAST_I[`TIMER_W-1:0];

    reg [2:0]          run_mode;      // Mode being timed
    reg [`TIMER_W-1:0] timer;         // Elapsed cycles
    reg                timed;         // Start code needs timing
    reg [`TIMER_W-1:0] last;          // Final count for run_mode

    // Only single conversion and the three calibrations are timed
    always @* begin
        case (start_mode)
            `OPM_SINGLE, `OPM_ZS_SELF, `OPM_CH_ZS, `OPM_CH_FS: timed = 1'b1;
            default: timed = 1'b0;
        endcase
        last = (run_mode == `OPM_SINGLE) ? CONV_LAST : CAL_LAST;
    end

    // Timer and completion pulse
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy      <= 1'b0;
            done      <= 1'b0;
            done_mode <= `OPM_IDLE;
            run_mode  <= `OPM_IDLE;
            timer     <= {`TIMER_W{1'b0}};
        end else if (soft_rst) begin
            // Serial reset aborts any operation
            busy      <= 1'b0;
            done      <= 1'b0;
            done_mode <= `OPM_IDLE;
            run_mode  <= `OPM_IDLE;
            timer     <= {`TIMER_W{1'b0}};
        end else begin
            done <= 1'b0;
            if (start) begin
                // Any mode write restarts or stops the timer
                busy     <= timed;
                run_mode <= start_mode;
                timer    <= {`TIMER_W{1'b0}};
            end else if (busy) begin
                if (timer == last) begin
                    busy      <= 1'b0;
                    done      <= 1'b1;
                    done_mode <= run_mode;
                end else begin
                    timer <= timer + 1'b1;
                end
            end
        end
    end

endmodule

/* tb/adc_serial_mode_control_chk.sv */
// Purpose: Port checker for the serial and mode control.
// Assumes: Watches only the top module's ports.
// Notes:   Link pins are seen raw, before synchronising.
`timescale 1ns/1ps
`include "adc_serial_defs.vh"
module adc_serial_mode_control_chk (
    // Clock and reset
    input wire        clk,
    input wire        arst_n,
    // Link
    input wire        sclk,
    input wire        cs_n,
    input wire        din,
    input wire        dout,
    input wire        dout_oe,
    // Converter state
    input wire        rdy_n,
    input wire [23:0] conv_result,
    input wire [2:0]  operating_mode_field,
    input wire        conv_busy
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    dout_off_a: assert property (cs_n [*8] |-> !dout_oe)
        else $error("dout enabled while deselected");
    busy_rdy_a: assert property (conv_busy |-> rdy_n)
        else $error("ready pin low during an operation");
    start_mode_a: assert property ($rose(conv_busy) |->
        operating_mode_field inside {`OPM_SINGLE, `OPM_ZS_SELF,
        `OPM_CH_ZS, `OPM_CH_FS})
        else $error("timed operation in an untimed mode");
    done_idle_a: assert property ($fell(conv_busy) |-> ##[0:2]
        operating_mode_field == `OPM_IDLE)
        else $error("mode not idle after operation");
    done_rdy_a: assert property ($fell(conv_busy) |-> ##[0:3] !rdy_n)
        else $error("ready pin not low after operation");
    fall_cause_a: assert property ($fell(rdy_n) |->
        !conv_busy && operating_mode_field == `OPM_IDLE)
        else $error("ready pin fell without completion");
    reset_idle_a: assert property ($rose(arst_n) |->
        rdy_n && !dout_oe && operating_mode_field == `OPM_IDLE)
        else $error("state not default after reset");
    dout_edge_a: assert property (dout_oe && $past(dout_oe)
        && $changed(dout) |-> !$past(sclk, 2))
        else $error("dout moved outside link clock low phase");

    cover property ($fell(rdy_n));
    cover property ($rose(conv_busy) && operating_mode_field == `OPM_CH_FS);
    cover property (cs_n && $fell(sclk));
endmodule

/* tb/adc_serial_mode_control_tb_top.sv */
// Purpose: Self-checking bench for the serial and mode control.
// Assumes: Host model drives the link; bench drives conv_result.
// Notes:   Each scenario judges its own results.
`timescale 1ns/1ps
module adc_serial_mode_control_tb_top;
    logic        clk = 1'b0;              // Core clock
    logic        arst_n = 1'b0;           // Reset pin
    wire         sclk, cs_n, din;         // Link from host
    wire         dout, dout_oe, rdy_n, conv_busy;
    wire  [2:0]  operating_mode_field;
    logic [23:0] conv_result = 24'h0;     // Filter result
    logic [63:0] rx;                      // Host receive word
    int          n_mismatch = 0;
    int          check_count = 0;

    // 40 MHz clock
    always #12.5 clk = ~clk;

    adc_serial_mode_control i_adc_serial_mode_control (.clk(clk),
        .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout), .dout_oe(dout_oe), .rdy_n(rdy_n),
        .conv_result(conv_result),
        .operating_mode_field(operating_mode_field),
        .conv_busy(conv_busy));
    host_model i_host_model (.sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout));

    // Compare and count
    task automatic check(input logic [63:0] seen, input logic [63:0] want);
        check_count++;
        if (seen !== want) begin
            n_mismatch++;
            $display("unexpected at %0t: seen %h want %h", $time, seen, want);
        end
    endtask

    // Verdict and end of run
    task automatic complete_run;
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Bounded wait for the ready pin
    task automatic wait_rdy;
        int k;
        for (k = 0; k < 6000 && rdy_n !== 1'b0; k++) @(posedge clk);
        check(k < 6000, 1);
    endtask

    // Single conversion on one channel, then read it
    task automatic t_single(input logic ch, input logic [23:0] v);
        @(posedge clk);
        #1 conv_result = v;
        i_host_model.xfer({7'h1c, ch, 8'h40}, 16, rx);
        check({conv_busy, rdy_n, operating_mode_field}, 5'h1a);
        wait_rdy();
        i_host_model.xfer(16'h4400, 16, rx);
        check({operating_mode_field, rx[7:0]}, {3'h0, 6'h0, ch, !ch});
        i_host_model.xfer({7'h24, ch, 16'h0}, 24, rx);
        check({rdy_n, rx[15:0]}, {1'b1, v[23:8]});
    endtask

    // Status prefix on data and on channel status reads
    task automatic t_dump;
        logic [7:0] rd [2] = '{8'h48, 8'h60};
        @(posedge clk);
        #1 conv_result = 24'h9b5a3c;
        i_host_model.xfer(16'h384a, 16, rx);
        wait_rdy();
        for (int i = 0; i < 2; i++) begin
            i_host_model.xfer({rd[i], 32'h0}, 40, rx);
            check(rx[31:0], 32'h049b5a3c);
        end
    endtask

    // All three calibrations and their registers
    task automatic t_cal;
        logic [2:0] code [3] = '{3'h4, 3'h6, 3'h7};
        logic [7:0] rd [3] = '{8'h68, 8'h70, 8'h72};
        for (int i = 0; i < 3; i++) begin
            @(posedge clk);
            #1 conv_result = 24'h123450 | 24'(i);
            i_host_model.xfer({8'h38, code[i], 5'h0}, 16, rx);
            wait_rdy();
            i_host_model.xfer(16'h4400, 16, rx);
            check({operating_mode_field, rx[7:0]}, 11'h003);
            i_host_model.xfer({rd[i], 24'h0}, 32, rx);
            check(rx[23:0], 24'h123450 | 24'(i));
        end
    endtask

    // Deselected traffic ignored; serial reset sequence
    task automatic t_sreset;
        i_host_model.xfer(16'h3860, 16, rx);
        i_host_model.xfer(16'h4400, 16, rx);
        check({rdy_n, rx[7:0]}, 9'h100);
        i_host_model.ghost(40);
        check({dout_oe, operating_mode_field}, 4'h3);
        i_host_model.xfer({8'h00, 32'hffffffff}, 40, rx);
        check({rdy_n, operating_mode_field}, 4'h8);
    endtask

    // Watchdog
    initial begin
        #2000000;
        n_mismatch++;
        complete_run();
    end

    // Main sequence
    initial begin
        repeat (6) @(posedge clk);
        #1 arst_n = 1'b1;
        @(posedge clk);
        #1 check({rdy_n, dout_oe, operating_mode_field}, 5'h10);
        t_single(1'b0, 24'ha5c3e1);
        t_single(1'b1, 24'h3c96f0);
        t_dump();
        t_cal();
        t_sreset();
        complete_run();
    end
endmodule

bind adc_serial_mode_control adc_serial_mode_control_chk i_chk (.clk(clk),
    .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .din(din), .dout(dout),
    .dout_oe(dout_oe), .rdy_n(rdy_n), .conv_result(conv_result),
    .operating_mode_field(operating_mode_field), .conv_busy(conv_busy));

/* tb/host_model.sv */
// Purpose: Host serial port model for the converter link.
// Assumes: Mode 3 framing, link clock period 200 ns.
// Notes:   Link clock stands high outside frames.
`timescale 1ns/1ps
module host_model (
    // Link pins
    output logic sclk,
    output logic cs_n,
    output logic din,
    input  wire  dout
);
    // Idle pins
    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din  = 1'b0;
    end

    // One frame: comms byte first, then one access, MSB first
    task automatic xfer(input logic [63:0] tx, input int n,
                        output logic [63:0] rx);
        rx = '0;
        cs_n = 1'b0;
        #400;
        for (int i = n - 1; i >= 0; i--) begin
            sclk = 1'b0;
            din  = tx[i];
            #100 sclk = 1'b1;
            #99 rx = {rx[62:0], dout};
            #1;
        end
        #400 cs_n = 1'b1;
        din = ~din;                       // Released line flips
        #400;
    endtask

    // Clock edges and ones while deselected
    task automatic ghost(input int n);
        din = 1'b1;
        repeat (n) begin
            #100 sclk = 1'b0;
            #100 sclk = 1'b1;
        end
    endtask
endmodule
